//--- tsp_consts.svh
// constants for the thermostat serial command port
// assumes inclusion by the design module and the testbench
// Functional notes
// - device acknowledges address, command and every data byte while addressed.
// - code ach selects configuration; one data byte follows the command in writes.
// - writing configuration clears the thermostat flag bits.
// - code a1h selects high threshold; following data bytes are stored there.
// - thresholds move as two bytes, msb first; msb holds whole degrees.
// - code a2h selects low threshold, same order and format as high.
// - code 51h starts conversion, no data, acknowledged, per configured mode.
// - reads send command, repeated start, address with read bit, device returns data.
// - code aah returns last conversion result msb first, one or two bytes.
// - code 22h stops continuous conversion; device idles until next start.
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH
`define TSP_ADDR_HI      4'h9
`define TSP_CMD_CONFIG   8'hac
`define TSP_CMD_HIGH     8'ha1
`define TSP_CMD_LOW      8'ha2
`define TSP_CMD_START    8'h51
`define TSP_CMD_STOP     8'h22
`define TSP_CMD_TEMP     8'haa
`define TSP_CFG_RESET    8'h8c
`define TSP_CFG_FLAGS    8'h60
`define TSP_THR_RESET    16'h0000
`endif

//--- tsp_pkg.sv
// types for the thermostat serial command port
// assumes tsp_consts.svh alongside
package tsp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } cmd_state_t;
endpackage

//--- byte_link_if.sv
// byte-level link between bit engine and command interpreter
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface byte_link_if;
  logic       start_seen;
  logic       stop_seen;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic       ack_en;
  logic       ack_take;
  logic [7:0] tx_byte;
  logic       tx_mode;
  logic       tx_nack;
  modport engine (output start_seen, stop_seen, byte_done, rx_byte, tx_nack,
                  input ack_en, ack_take, tx_byte, tx_mode);
  modport interp (input start_seen, stop_seen, byte_done, rx_byte, tx_nack,
                  output ack_en, ack_take, tx_byte, tx_mode);
endinterface
`default_nettype wire

//--- serial_bit_engine.sv
// bit engine: start/stop detect, shift, acknowledge drive
// assumes scl/sda sampled synchronous to mclk_i
`timescale 1ns/100ps
`default_nettype none
module serial_bit_engine (
  input  wire logic    mclk_i,
  input  wire logic    rstn_i,
  input  wire logic    scl_i,
  input  wire logic    sda_i,
  output logic         sda_oe_o,
  byte_link_if.engine  lk
);
  typedef struct packed {
    logic       scl_d;
    logic       sda_d;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic       ackph;
    logic       oe;
    logic       act;
    logic       s;
    logic       p;
    logic       done;
    logic       nack;
  } eng_t;
  eng_t eng_reg, eng_next;

  always_comb begin
    eng_next = eng_reg;
    eng_next.scl_d = scl_i;
    eng_next.sda_d = sda_i;
    eng_next.s = 1'b0;
    eng_next.p = 1'b0;
    eng_next.done = 1'b0;
    // ----------------------------------------
    // start and stop conditions
    // ----------------------------------------
    if (scl_i && eng_reg.scl_d && eng_reg.sda_d && !sda_i) begin
      eng_next.s = 1'b1;
      eng_next.act = 1'b1;
      eng_next.bitcnt = 4'h0;
      eng_next.ackph = 1'b0;
      eng_next.oe = 1'b0;
    end else if (scl_i && eng_reg.scl_d && !eng_reg.sda_d && sda_i) begin
      eng_next.p = 1'b1;
      eng_next.act = 1'b0;
      eng_next.oe = 1'b0;
    end else if (eng_reg.act && scl_i && !eng_reg.scl_d) begin
      if (eng_reg.ackph) begin
        eng_next.nack = sda_i;
      end else begin
        eng_next.sh = {eng_reg.sh[6:0], sda_i};
        eng_next.bitcnt = eng_reg.bitcnt + 4'h1;
        if (eng_reg.bitcnt == 4'h7) begin
          eng_next.done = 1'b1;
        end
      end
    end else if (eng_reg.act && !scl_i && eng_reg.scl_d) begin
      if (!eng_reg.ackph && eng_reg.bitcnt == 4'h8) begin
        eng_next.ackph = 1'b1;
        eng_next.bitcnt = 4'h0;
        eng_next.oe = lk.ack_en;
      end else begin
        if (eng_reg.ackph) begin
          eng_next.ackph = 1'b0;
          if (lk.ack_take) begin
            eng_next.sh = lk.tx_byte;
          end
        end
        // shifter moves up each bit, so the next bit is always the top one
        eng_next.oe = lk.tx_mode && !eng_next.ackph && !eng_next.nack
                      && !eng_next.sh[7];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eng_reg <= '{scl_d: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      eng_reg <= eng_next;
    end
  end

  assign sda_oe_o = eng_reg.oe;
  assign lk.start_seen = eng_reg.s;
  assign lk.stop_seen = eng_reg.p;
  assign lk.byte_done = eng_reg.done;
  assign lk.rx_byte = eng_reg.sh;
  assign lk.tx_nack = eng_reg.nack;
endmodule
`default_nettype wire

//--- thermostat_serial_command_port.sv
// command interpreter behind the two-wire slave port
// assumes scl/sda synchronous to mclk_i; temperature comes from the converter
`timescale 1ns/100ps
`default_nettype none
`include "tsp_consts.svh"
module thermostat_serial_command_port (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [2:0]  addr_sel_i,
  input  wire logic [15:0] temperature_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic [7:0]       config_o,
  output logic [15:0]      high_alarm_threshold_o,
  output logic [15:0]      low_alarm_threshold_o,
  output logic             conv_start_o,
  output logic             conv_stop_o,
  output logic             flags_clear_o
);

  // ----------------------------------------
  // interpreter state
  // ----------------------------------------
  typedef struct packed {
    tsp_pkg::cmd_state_t st;
    logic [7:0]          cmd;
    logic                first;
    logic                rdmode;
    logic [7:0]          cfg;
    logic [15:0]         th;
    logic [15:0]         tl;
    logic                start_p;
    logic                stop_p;
    logic                fclr_p;
    logic [15:0]         tsnap;
    logic                rdack;
    logic                oe;
  } core_t;
  core_t       core_reg, core_next;
  byte_link_if lk ();
  logic        eng_oe;

  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  serial_bit_engine u_eng (
    .mclk_i   (mclk_i),
    .rstn_i   (rstn_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .sda_oe_o (eng_oe),
    .lk       (lk)
  );

  // ----------------------------------------
  // address and command decoding
  // ----------------------------------------
  function automatic logic addr_match(input logic [7:0] a, input logic [2:0] sel);
    addr_match = (a[7:1] == {`TSP_ADDR_HI, sel});
  endfunction

  function automatic logic known_cmd(input logic [7:0] c);
    known_cmd = (c == `TSP_CMD_CONFIG)
                || (c == `TSP_CMD_HIGH)
                || (c == `TSP_CMD_LOW)
                || (c == `TSP_CMD_TEMP);
  endfunction

  // ----------------------------------------
  // read data selection
  // ----------------------------------------
  function automatic logic [7:0] read_byte(input logic [7:0]  cmd,
                                           input logic        first,
                                           input logic [7:0]  cfg,
                                           input logic [15:0] th,
                                           input logic [15:0] tl,
                                           input logic [15:0] t);
    logic [15:0] w;
    w = 16'h0000;
    if (cmd == `TSP_CMD_CONFIG) begin
      w = {cfg, cfg};
    end else if (cmd == `TSP_CMD_HIGH) begin
      w = th;
    end else if (cmd == `TSP_CMD_LOW) begin
      w = tl;
    end else if (cmd == `TSP_CMD_TEMP) begin
      w = t;
    end
    read_byte = first ? w[15:8] : w[7:0];
  endfunction

  // ----------------------------------------
  // acknowledge and transmit control
  // ----------------------------------------
  always_comb begin
    lk.ack_en = 1'b0;
    lk.ack_take = 1'b0;
    lk.tx_mode = (core_reg.st == tsp_pkg::ST_RDATA);
    lk.tx_byte = read_byte(core_reg.cmd,
                           core_reg.first,
                           core_reg.cfg,
                           core_reg.th,
                           core_reg.tl,
                           core_reg.tsnap);
    case (core_reg.st)
      tsp_pkg::ST_ADDR: begin
        lk.ack_en = addr_match(lk.rx_byte, addr_sel_i);
      end
      tsp_pkg::ST_CMD, tsp_pkg::ST_WDATA, tsp_pkg::ST_IGNORE: begin
        lk.ack_en = 1'b1;
      end
      tsp_pkg::ST_RDATA: begin
        lk.ack_en = core_reg.rdack;
        lk.ack_take = 1'b1;
      end
      default: begin
        lk.ack_en = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // command sequencing
  // ----------------------------------------
  always_comb begin
    core_next = core_reg;
    core_next.start_p = 1'b0;
    core_next.stop_p = 1'b0;
    core_next.fclr_p = 1'b0;
    core_next.oe = eng_oe;
    if (lk.start_seen) begin
      core_next.st = tsp_pkg::ST_ADDR;
    end else if (lk.stop_seen) begin
      core_next.st = tsp_pkg::ST_IDLE;
    end else if (lk.byte_done) begin
      case (core_reg.st)
        tsp_pkg::ST_ADDR: begin
          if (!addr_match(lk.rx_byte, addr_sel_i)) begin
            core_next.st = tsp_pkg::ST_IDLE;
          end else if (lk.rx_byte[0]) begin
            core_next.st = tsp_pkg::ST_RDATA;
            core_next.first = 1'b1;
            core_next.rdack = 1'b1;
            // snapshot so both bytes come from one result
            core_next.tsnap = temperature_i;
          end else begin
            core_next.st = tsp_pkg::ST_CMD;
          end
        end
        tsp_pkg::ST_CMD: begin
          core_next.cmd = lk.rx_byte;
          core_next.first = 1'b1;
          core_next.st = tsp_pkg::ST_WDATA;
          if (lk.rx_byte == `TSP_CMD_START) begin
            core_next.start_p = 1'b1;
            core_next.st = tsp_pkg::ST_IGNORE;
          end else if (lk.rx_byte == `TSP_CMD_STOP) begin
            core_next.stop_p = 1'b1;
            core_next.st = tsp_pkg::ST_IGNORE;
          end else if (!known_cmd(lk.rx_byte)) begin
            core_next.st = tsp_pkg::ST_IGNORE;
          end
        end
        tsp_pkg::ST_WDATA: begin
          core_next.first = 1'b0;
          if (core_reg.cmd == `TSP_CMD_CONFIG) begin
            if (core_reg.first) begin
              core_next.cfg = lk.rx_byte & ~`TSP_CFG_FLAGS;
              core_next.fclr_p = 1'b1;
            end
          end else if (core_reg.cmd == `TSP_CMD_HIGH) begin
            if (core_reg.first) begin
              core_next.th[15:8] = lk.rx_byte;
            end else begin
              core_next.th[7:0] = lk.rx_byte;
            end
          end else if (core_reg.cmd == `TSP_CMD_LOW) begin
            if (core_reg.first) begin
              core_next.tl[15:8] = lk.rx_byte;
            end else begin
              core_next.tl[7:0] = lk.rx_byte;
            end
          end
        end
        tsp_pkg::ST_RDATA: begin
          core_next.first = 1'b0;
          core_next.rdack = 1'b0;
        end
        default: begin
          core_next.st = core_reg.st;
        end
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      core_reg <= '{st: tsp_pkg::ST_IDLE, cfg: `TSP_CFG_RESET, th: `TSP_THR_RESET,
                    tl: `TSP_THR_RESET, default: '0};
    end else begin
      core_reg <= core_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sda_o = 1'b0;
  assign sda_oe_o = core_reg.oe;
  assign config_o = core_reg.cfg;
  assign high_alarm_threshold_o = core_reg.th;
  assign low_alarm_threshold_o = core_reg.tl;
  assign conv_start_o = core_reg.start_p;
  assign conv_stop_o = core_reg.stop_p;
  assign flags_clear_o = core_reg.fclr_p;
endmodule
`default_nettype wire

//--- tsp_props.sv
// checker for the thermostat serial command port
// assumes binding to the top module, one clock domain
`timescale 1ns/100ps
`default_nettype none
module tsp_props (
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic [7:0]  config_o,
  input wire logic [15:0] high_alarm_threshold_o,
  input wire logic [15:0] low_alarm_threshold_o,
  input wire logic        conv_start_o,
  input wire logic        conv_stop_o,
  input wire logic        flags_clear_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  AST_PULL_IN_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("pull began with scl high");
  AST_FREE_IN_LOW: assert property ($fell(sda_oe_o) |-> !scl_i)
    else $error("release with scl high");
  AST_PULL_IS_LOW: assert property ((sda_oe_o && $rose(scl_i)) |=> sda_oe_o && sda_o == 1'b0)
    else $error("pull dropped during scl high");
  AST_CFG_FLAGS: assert property ($changed(config_o) |-> (config_o & 8'h60) == 8'h00)
    else $error("flags kept on config write");
  AST_CFG_CLEAR: assert property ($changed(config_o) |-> flags_clear_o || $past(flags_clear_o)
    || $past(flags_clear_o, 2)) else $error("config changed without clear");
  AST_START_ONE: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  AST_STOP_ONE: assert property (conv_stop_o |=> !conv_stop_o && !conv_start_o)
    else $error("stop pulse bad");
  AST_ONE_TARGET: assert property ($changed(high_alarm_threshold_o)
    |-> $stable(low_alarm_threshold_o) && $stable(config_o)) else $error("two registers changed");
endmodule
`default_nettype wire

//--- tsp_master.sv
// two-wire bus master model driving clock and data
// assumes device pulls data low via sda_oe_i, pull-up otherwise
`timescale 1ns/100ps
`default_nettype none
module tsp_master #(
  parameter int PH = 6
) (
  input  wire logic mclk_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic drv_low;
  assign sda_o = ~(drv_low | sda_oe_i);
  initial begin
    scl_o = 1'b1;
    drv_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // start or repeated start
  task automatic start();
    drv_low = 1'b0;
    wt(PH);
    scl_o = 1'b1;
    wt(PH);
    drv_low = 1'b1;
    wt(PH);
    scl_o = 1'b0;
    wt(2);
  endtask
  task automatic stop();
    drv_low = 1'b1;
    wt(PH);
    scl_o = 1'b1;
    wt(PH);
    drv_low = 1'b0;
    wt(PH);
  endtask
  // eight bits plus acknowledge slot, msb first
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      drv_low = ~d[i];
      wt(PH);
      scl_o = 1'b1;
      wt(PH);
      q[i] = sda_o;
      scl_o = 1'b0;
      wt(2);
    end
  endtask
endmodule
`default_nettype wire

//--- thermostat_serial_command_port_test.sv
// testbench for the thermostat serial command port
// assumes tsp_master as bus master and tsp_props as checker
`timescale 1ns/100ps
`default_nettype none
`include "tsp_consts.svh"
module thermostat_serial_command_port_test;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        scl_i, sda_i, sda_o, sda_oe_o, conv_start_o, conv_stop_o, flags_clear_o;
  logic [2:0]  addr_sel_i = 3'h5;
  logic [15:0] temperature_i = 16'h1a50;
  logic [7:0]  config_o;
  logic [15:0] high_alarm_threshold_o, low_alarm_threshold_o;
  logic [8:0]  q;
  int          fails = 0;
  int          compares = 0;
  int          n_start = 0;
  int          n_stop = 0;
  int          n_clr = 0;
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    n_start <= n_start + int'(conv_start_o === 1'b1);
    n_stop <= n_stop + int'(conv_stop_o === 1'b1);
    n_clr <= n_clr + int'(flags_clear_o === 1'b1);
  end
  tsp_master m (.mclk_i(mclk_i), .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
  thermostat_serial_command_port u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i),
    .addr_sel_i(addr_sel_i), .temperature_i(temperature_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .config_o(config_o), .high_alarm_threshold_o(high_alarm_threshold_o),
    .low_alarm_threshold_o(low_alarm_threshold_o), .conv_start_o(conv_start_o),
    .conv_stop_o(conv_stop_o), .flags_clear_o(flags_clear_o));
  task automatic results();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic acked);
    m.xfer({b, 1'b1}, q);
    chk(16'(q[0]), 16'(!acked));
  endtask
  task automatic cmd(input logic [7:0] c, input logic rd);
    m.start();
    send({`TSP_ADDR_HI, addr_sel_i, rd}, 1'b1);
    if (!rd) send(c, 1'b1);
  endtask
  task automatic t_config();
    cmd(`TSP_CMD_CONFIG, 1'b0);
    send(8'h68, 1'b1);
    chk(16'(n_clr), 16'h0001);
    send(8'h6f, 1'b1);
    chk(16'(config_o), 16'h0008);
    cmd(`TSP_CMD_CONFIG, 1'b0);
    cmd(8'h00, 1'b1);
    m.xfer(9'h1ff, q);
    chk(16'(q[8:1]), 16'h0008);
    m.stop();
  endtask
  task automatic t_thresh();
    cmd(`TSP_CMD_HIGH, 1'b0);
    send(8'h32, 1'b1);
    send(8'h80, 1'b1);
    chk(high_alarm_threshold_o, 16'h3280);
    cmd(`TSP_CMD_LOW, 1'b0);
    send(8'h2d, 1'b1);
    send(8'h00, 1'b1);
    chk(low_alarm_threshold_o, 16'h2d00);
  endtask
  task automatic t_conv();
    cmd(`TSP_CMD_START, 1'b0);
    chk(16'(n_start), 16'h0001);
    cmd(`TSP_CMD_STOP, 1'b0);
    chk(16'(n_stop), 16'h0001);
    cmd(`TSP_CMD_TEMP, 1'b0);
    cmd(8'h00, 1'b1);
    m.xfer(9'h1fe, q);
    chk(16'(q[8:1]), 16'h001a);
    m.xfer(9'h1ff, q);
    chk(16'(q[8:1]), 16'h0050);
    m.stop();
  endtask
  task automatic t_refuse();
    m.start();
    send({`TSP_ADDR_HI, addr_sel_i ^ 3'h1, 1'b0}, 1'b0);
    send(`TSP_CMD_CONFIG, 1'b0);
    send(8'h00, 1'b0);
    chk(16'(config_o), 16'h0008);
    cmd(8'h77, 1'b0);
    send(8'h00, 1'b1);
    send(8'h00, 1'b1);
    chk(16'(config_o), 16'h0008);
    chk(high_alarm_threshold_o, 16'h3280);
    m.stop();
  endtask
  initial begin
    repeat (12) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    t_config();
    t_thresh();
    t_conv();
    t_refuse();
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    results();
  end
endmodule
bind thermostat_serial_command_port tsp_props u_props (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl_i(scl_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .config_o(config_o), .high_alarm_threshold_o(high_alarm_threshold_o),
  .low_alarm_threshold_o(low_alarm_threshold_o), .conv_start_o(conv_start_o), .conv_stop_o(conv_stop_o),
  .flags_clear_o(flags_clear_o));
`default_nettype wire
